// ### logic/iolcm_out_mux.sv
// Per-line output path: ownership, function select and open drain
`timescale 1ns/1ps
`default_nettype none
module iolcm_out_mux (
   input wire iolcm_pkg::iolcm_vec_type own,
   input wire iolcm_pkg::iolcm_vec_type sel_lo,
   input wire iolcm_pkg::iolcm_vec_type sel_hi,
   input wire iolcm_pkg::iolcm_vec_type drive,
   input wire iolcm_pkg::iolcm_vec_type level,
   input wire iolcm_pkg::iolcm_vec_type open_drain,
   input wire logic [4*iolcm_pkg::LINES-1:0] fn_out,
   input wire logic [4*iolcm_pkg::LINES-1:0] fn_oe,
   input wire logic [4*iolcm_pkg::LINES-1:0] present,
   output logic [iolcm_pkg::LINES-1:0] next_pad_out,
   output logic [iolcm_pkg::LINES-1:0] next_pad_oe
);
   import iolcm_pkg::*;
   genvar i;
   // One slice per line
   generate
      for (i = 0; i < LINES; i = i + 1) begin : g_line
         wire [1:0] code; // Function code A=0 .. D=3
         wire [5:0] idx; // Function code times 16; not used to index the function busses
         wire fn_here; // Selected function exists on this line
         wire raw_val; // Level before open-drain shaping
         wire raw_oe; // Enable before open-drain shaping
         assign code = {sel_hi[i], sel_lo[i]};
         assign idx = {code, 4'h0} ^ 6'h00;
         // Unknown function: stored, but nothing drives
         assign fn_here = present[{code, 5'(i)}];
         // Controller owns: drive/level; else the function
         assign raw_val = own[i] ? level[i] : fn_out[{code, 5'(i)}];
         assign raw_oe = own[i] ? drive[i]
                                : (fn_here & fn_oe[{code, 5'(i)}]);
         // Open drain only ever pulls low, in either ownership
         assign next_pad_out[i] = raw_val & ~open_drain[i];
         assign next_pad_oe[i] = raw_oe & ~(open_drain[i] & raw_val);
      end
   endgenerate
endmodule
`default_nettype wire

// ### logic/iolcm_pkg.sv
// Package: register map, reset values and widths of the I/O line block
package iolcm_pkg;
   localparam int LINES = 32; // Lines per controller
   localparam int AW = 8; // APB address width
   typedef logic [LINES-1:0] iolcm_vec_type;
   // Register byte addresses
   localparam logic [AW-1:0] ADDR_OWN_ON = 8'h00;
   localparam logic [AW-1:0] ADDR_OWN_OFF = 8'h04;
   localparam logic [AW-1:0] ADDR_OWN_ST = 8'h08;
   localparam logic [AW-1:0] ADDR_DRV_ON = 8'h10;
   localparam logic [AW-1:0] ADDR_DRV_OFF = 8'h14;
   localparam logic [AW-1:0] ADDR_DRV_ST = 8'h18;
   localparam logic [AW-1:0] ADDR_LVL_SET = 8'h30;
   localparam logic [AW-1:0] ADDR_LVL_CLR = 8'h34;
   localparam logic [AW-1:0] ADDR_LVL_ST = 8'h38;
   localparam logic [AW-1:0] ADDR_PIN = 8'h3c;
   localparam logic [AW-1:0] ADDR_OD_ON = 8'h50;
   localparam logic [AW-1:0] ADDR_OD_OFF = 8'h54;
   localparam logic [AW-1:0] ADDR_OD_ST = 8'h58;
   localparam logic [AW-1:0] ADDR_PU_OFF = 8'h60;
   localparam logic [AW-1:0] ADDR_PU_ON = 8'h64;
   localparam logic [AW-1:0] ADDR_PU_ST = 8'h68;
   localparam logic [AW-1:0] ADDR_SEL_LO = 8'h70;
   localparam logic [AW-1:0] ADDR_SEL_HI = 8'h74;
   localparam logic [AW-1:0] ADDR_PD_OFF = 8'h90;
   localparam logic [AW-1:0] ADDR_PD_ON = 8'h94;
   localparam logic [AW-1:0] ADDR_PD_ST = 8'h98;
   localparam logic [AW-1:0] ADDR_DW_ON = 8'ha0;
   localparam logic [AW-1:0] ADDR_DW_OFF = 8'ha4;
   localparam logic [AW-1:0] ADDR_DW_ST = 8'ha8;
   localparam logic [AW-1:0] ADDR_CLK = 8'hb0;
   localparam int CLK_ON_BIT = 0; // Peripheral clock enable bit
   // Reset values
   localparam iolcm_vec_type RST_ZERO = 32'h0000_0000;
   localparam iolcm_vec_type RST_ONES = 32'hffff_ffff;
   localparam iolcm_vec_type RST_OWN = 32'hffff_ffff;
   localparam iolcm_vec_type RST_PU = 32'h0000_0000;
   localparam iolcm_vec_type RST_PD = 32'hffff_ffff;
   localparam iolcm_vec_type RST_MUXED = 32'hffff_ffff;
   localparam logic [4*LINES-1:0] RST_PRESENT = {4{32'hffff_ffff}};
endpackage

// ### logic/iolcm_top.sv
// I/O line control and peripheral multiplexer with APB register file
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iolcm_top #(
   parameter iolcm_pkg::iolcm_vec_type OWN_RESET = iolcm_pkg::RST_OWN,
   parameter iolcm_pkg::iolcm_vec_type MUXED = iolcm_pkg::RST_MUXED,
   parameter iolcm_pkg::iolcm_vec_type PU_RESET = iolcm_pkg::RST_PU,
   parameter iolcm_pkg::iolcm_vec_type PD_RESET = iolcm_pkg::RST_PD,
   parameter logic [4*iolcm_pkg::LINES-1:0] PRESENT =
      iolcm_pkg::RST_PRESENT
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [iolcm_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire iolcm_pkg::iolcm_vec_type pad_in,
   output iolcm_pkg::iolcm_vec_type pad_out,
   output iolcm_pkg::iolcm_vec_type pad_oe,
   output iolcm_pkg::iolcm_vec_type pad_pullup_off,
   output iolcm_pkg::iolcm_vec_type pad_pulldown_off,
   input wire logic [4*iolcm_pkg::LINES-1:0] fn_out,
   input wire logic [4*iolcm_pkg::LINES-1:0] fn_oe,
   output iolcm_pkg::iolcm_vec_type periph_in
);
   import iolcm_pkg::*;

   // Status registers
   iolcm_vec_type ownership_state; // One: controller drives
   iolcm_vec_type func_select_lo; // First select bit
   iolcm_vec_type func_select_hi; // Second select bit
   iolcm_vec_type drive_state; // One: output enabled
   iolcm_vec_type level_state; // Level when driven
   iolcm_vec_type direct_write_mask; // Direct level write mask
   iolcm_vec_type open_drain_state; // One: open drain
   iolcm_vec_type pullup_state; // One: pull-up off
   iolcm_vec_type pulldown_state; // One: pull-down off
   logic clk_on; // Peripheral clock enable
   iolcm_vec_type pin_level; // Pin level seen by software
   // Pin synchroniser
   iolcm_vec_type sync1; // First stage, read by sync2 only
   iolcm_vec_type sync2; // Second stage
   iolcm_vec_type sync3; // Third stage
   iolcm_vec_type pin_seen; // Settled pin level
   // Bus decode and line mux results
   logic [31:0] next_prdata; // Read mux result
   logic next_err; // Unmapped address
   iolcm_vec_type next_pad_out; // Line mux level
   iolcm_vec_type next_pad_oe; // Line mux enable

   // Write strobe for one register address
   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [AW-1:0] t,
                                input logic we);
      hit = we && (a == t);
   endfunction

   // Set/clear update: only written ones act
   function automatic iolcm_vec_type setclr(input iolcm_vec_type cur,
                                            input logic s,
                                            input logic c,
                                            input iolcm_vec_type d);
      iolcm_vec_type r;
      r = cur;
      if (s) begin
         r = r | d;
      end
      if (c) begin
         r = r & ~d;
      end
      setclr = r;
   endfunction

   wire setup = psel & ~penable; // APB setup phase
   // Write commits only in the access cycle with pready high
   wire we = psel & penable & pready & pwrite;
   wire [31:0] wd = pwdata; // Write data alias
   wire w_own_on = hit(paddr, ADDR_OWN_ON, we);
   wire w_own_off = hit(paddr, ADDR_OWN_OFF, we);
   wire w_drv_on = hit(paddr, ADDR_DRV_ON, we);
   wire w_drv_off = hit(paddr, ADDR_DRV_OFF, we);
   wire w_lvl_set = hit(paddr, ADDR_LVL_SET, we);
   wire w_lvl_clr = hit(paddr, ADDR_LVL_CLR, we);
   wire w_lvl_st = hit(paddr, ADDR_LVL_ST, we);
   wire w_od_on = hit(paddr, ADDR_OD_ON, we);
   wire w_od_off = hit(paddr, ADDR_OD_OFF, we);
   wire w_pu_on = hit(paddr, ADDR_PU_ON, we);
   wire w_pu_off = hit(paddr, ADDR_PU_OFF, we);
   wire w_pd_on = hit(paddr, ADDR_PD_ON, we);
   wire w_pd_off = hit(paddr, ADDR_PD_OFF, we);
   wire w_sel_lo = hit(paddr, ADDR_SEL_LO, we);
   wire w_sel_hi = hit(paddr, ADDR_SEL_HI, we);
   wire w_dw_on = hit(paddr, ADDR_DW_ON, we);
   wire w_dw_off = hit(paddr, ADDR_DW_OFF, we);
   wire w_clk = hit(paddr, ADDR_CLK, we);
   // A pull enable only lands where the other pull is off
   wire [31:0] pu_on_ok = wd & pulldown_state;
   wire [31:0] pd_on_ok = wd & pullup_state;
   // Unmuxed lines take no ownership or select writes
   wire [31:0] wd_mux = wd & MUXED;
   // Masked direct write
   wire [31:0] lvl_direct =
      (level_state & ~direct_write_mask) | (wd & direct_write_mask);

   // Read mux; reserved space reads zero and flags an error
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_err = 1'b0;
      case (paddr)
         ADDR_OWN_ST: next_prdata = ownership_state;
         ADDR_SEL_LO: next_prdata = func_select_lo;
         ADDR_SEL_HI: next_prdata = func_select_hi;
         ADDR_DRV_ST: next_prdata = drive_state;
         ADDR_LVL_ST: next_prdata = level_state;
         ADDR_PIN: next_prdata = pin_level;
         ADDR_OD_ST: next_prdata = open_drain_state;
         ADDR_PU_ST: next_prdata = pullup_state;
         ADDR_PD_ST: next_prdata = pulldown_state;
         ADDR_DW_ST: next_prdata = direct_write_mask;
         ADDR_CLK: next_prdata = {31'h0000_0000, clk_on};
         // Write-only strobes read as zero
         ADDR_OWN_ON, ADDR_OWN_OFF, ADDR_DRV_ON, ADDR_DRV_OFF,
         ADDR_LVL_SET, ADDR_LVL_CLR, ADDR_OD_ON, ADDR_OD_OFF,
         ADDR_PU_ON, ADDR_PU_OFF, ADDR_PD_ON, ADDR_PD_OFF,
         ADDR_DW_ON, ADDR_DW_OFF: next_prdata = 32'h0000_0000;
         default: next_err = 1'b1;
      endcase
   end

   // APB answer: one wait-free access cycle after each setup
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= setup ? next_prdata : 32'h0000_0000;
         pslverr <= setup & next_err;
      end
   end

   // Ownership and function select; no clock gate on writes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ownership_state <= OWN_RESET | ~MUXED;
         func_select_lo <= RST_ZERO;
         func_select_hi <= RST_ZERO;
      end else begin
         ownership_state <= setclr(ownership_state, w_own_on,
                                   w_own_off, wd_mux);
         // Stored whatever the ownership or code
         if (w_sel_lo) begin
            func_select_lo <= (func_select_lo & ~MUXED) | wd_mux;
         end
         if (w_sel_hi) begin
            func_select_hi <= (func_select_hi & ~MUXED) | wd_mux;
         end
      end
   end

   // Drive, level and mask; held even while peripheral owned
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_state <= RST_ZERO;
         level_state <= RST_ZERO;
         direct_write_mask <= RST_ZERO;
      end else begin
         drive_state <= setclr(drive_state, w_drv_on, w_drv_off,
                               wd);
         level_state <= w_lvl_st ? lvl_direct :
            setclr(level_state, w_lvl_set, w_lvl_clr, wd);
         direct_write_mask <= setclr(direct_write_mask, w_dw_on,
                                     w_dw_off, wd);
      end
   end

   // Pulls and open drain
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pullup_state <= PU_RESET;
         pulldown_state <= PD_RESET;
         open_drain_state <= RST_ZERO;
      end else begin
         pullup_state <= setclr(pullup_state, w_pu_off, w_pu_on,
            w_pu_on ? pu_on_ok : wd);
         pulldown_state <= setclr(pulldown_state, w_pd_off, w_pd_on,
            w_pd_on ? pd_on_ok : wd);
         open_drain_state <= setclr(open_drain_state, w_od_on,
                                    w_od_off, wd);
      end
   end

   // Peripheral clock gate starts off
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_on <= 1'b0;
      end else if (w_clk) begin
         clk_on <= wd[CLK_ON_BIT];
      end
   end

   // Three-stage pin sampling; a change counts once sync2 and sync3 agree
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= RST_ZERO;
         sync2 <= RST_ZERO;
         sync3 <= RST_ZERO;
         pin_seen <= RST_ZERO;
      end else begin
         sync1 <= pad_in;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_seen <= (pin_seen & (sync2 ^ sync3)) |
                     (sync3 & ~(sync2 ^ sync3));
      end
   end

   // Peripherals always see the pin; software only with clock on
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         periph_in <= RST_ZERO;
         pin_level <= RST_ZERO;
      end else begin
         periph_in <= pin_seen;
         // Frozen at the last seen level while gated
         if (clk_on) begin
            pin_level <= pin_seen;
         end
      end
   end

   // Per-line output selection
   iolcm_out_mux u_mux (
      .own(ownership_state),
      .sel_lo(func_select_lo),
      .sel_hi(func_select_hi),
      .drive(drive_state),
      .level(level_state),
      .open_drain(open_drain_state),
      .fn_out(fn_out),
      .fn_oe(fn_oe),
      .present(PRESENT),
      .next_pad_out(next_pad_out),
      .next_pad_oe(next_pad_oe)
   );

   // Pad outputs registered to avoid glitches on the pins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pad_out <= RST_ZERO;
         pad_oe <= RST_ZERO;
         pad_pullup_off <= PU_RESET;
         pad_pulldown_off <= PD_RESET;
      end else begin
         pad_out <= next_pad_out;
         pad_oe <= next_pad_oe;
         pad_pullup_off <= pullup_state;
         pad_pulldown_off <= pulldown_state;
      end
   end

   // Checks
   AST_PU_OFF: assert property (@(posedge clk) disable iff (!reset_n)
      w_pu_off |=> (pullup_state & $past(wd)) == $past(wd))
      else $error("pull-up disable did not set status");
   AST_PD_DISCARD: assert property (@(posedge clk)
      disable iff (!reset_n)
      w_pd_on |=> (pulldown_state & $past(~pullup_state)) ==
         $past(pulldown_state & ~pullup_state))
      else $error("pull-down enabled while pull-up active");
   AST_PD_ON: assert property (@(posedge clk) disable iff (!reset_n)
      w_pd_on |=> (pulldown_state & $past(pd_on_ok)) == 32'h0)
      else $error("pull-down enable did not clear status");
   AST_OWN_FIXED: assert property (@(posedge clk)
      disable iff (!reset_n)
      (ownership_state | MUXED) == RST_ONES)
      else $error("unmuxed line lost controller ownership");
   AST_OWN_OFF: assert property (@(posedge clk) disable iff (!reset_n)
      w_own_off |=> (ownership_state & $past(wd_mux)) == 32'h0)
      else $error("ownership disable ignored");
   AST_DIRECT: assert property (@(posedge clk) disable iff (!reset_n)
      w_lvl_st |=> level_state == $past(lvl_direct)
         && ($past(level_state) ^ level_state &
             ~$past(direct_write_mask)) == 32'h0)
      else $error("direct write touched masked line");
   AST_OD_LOW: assert property (@(posedge clk) disable iff (!reset_n)
      (pad_oe & pad_out & $past(open_drain_state)) == 32'h0)
      else $error("open-drain line driven high");
   AST_GATED: assert property (@(posedge clk) disable iff (!reset_n)
      !clk_on |=> $stable(pin_level))
      else $error("pin level changed with clock gated");
   AST_PIN_IN: assert property (@(posedge clk) disable iff (!reset_n)
      (sync2 == sync3) |=> ##1 periph_in == $past(sync3, 2))
      else $error("peripheral input not following pin");
   AST_DRV_ON: assert property (@(posedge clk) disable iff (!reset_n)
      w_drv_on |=> (drive_state & $past(wd)) == $past(wd))
      else $error("drive enable write lost");
endmodule
`default_nettype wire

// ### testbench/io_line_control_mux_tb.sv
// Self-checking bench for the I/O line control block
`timescale 1ns/1ps
`default_nettype none
module io_line_control_mux_tb;
   import iolcm_pkg::*;
   typedef struct {
      logic [AW-1:0] wa; // Address written
      logic [31:0] wd; // Data written
      logic [AW-1:0] ra; // Status address read back
      logic [31:0] ex; // Expected status
   } iolcm_row_type;
   // Lines 8-15 start peripheral owned; line 0 has no peripheral
   localparam iolcm_vec_type OWN_RST = 32'hffff_00ff;
   localparam iolcm_vec_type MUX = 32'hffff_fffe;
   // Function patterns, D first: D never drives, A leaves 12-15 free
   localparam logic [127:0] F_OUT = {32'h5555_5555, 32'haaaa_aaaa,
      32'hffff_0000, 32'h0f0f_0f0f};
   localparam logic [127:0] F_OE = {32'h0000_0000, 32'hffff_ffff,
      32'hffff_ffff, 32'hffff_0fff};
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   iolcm_vec_type pad_in, pad_out, pad_oe, pu_off, pd_off, periph_in;
   iolcm_vec_type ext_level, old;
   logic [127:0] fn_out, fn_oe;
   int failures, n_compared;
   // Register effects in order; each row builds on the ones before
   iolcm_row_type rows [17] = '{
      '{ADDR_DRV_ON, 32'hffff_0000, ADDR_DRV_ST, 32'hffff_0000},
      '{ADDR_DRV_OFF, 32'h0f00_0000, ADDR_DRV_ST, 32'hf0ff_0000},
      '{ADDR_LVL_SET, 32'h1234_5678, ADDR_LVL_ST, 32'h1234_5678},
      '{ADDR_LVL_CLR, 32'h0000_0078, ADDR_LVL_ST, 32'h1234_5600},
      '{ADDR_LVL_ST, 32'hffff_ffff, ADDR_LVL_ST, 32'h1234_5600},
      '{ADDR_DW_ON, 32'h0000_00ff, ADDR_DW_ST, 32'h0000_00ff},
      '{ADDR_LVL_ST, 32'h0000_0011, ADDR_LVL_ST, 32'h1234_5611},
      '{ADDR_DW_OFF, 32'h0000_000f, ADDR_DW_ST, 32'h0000_00f0},
      '{ADDR_OD_ON, 32'h8000_0001, ADDR_OD_ST, 32'h8000_0001},
      '{ADDR_OD_OFF, 32'h8000_0000, ADDR_OD_ST, 32'h0000_0001},
      '{ADDR_PU_OFF, 32'h0000_ffff, ADDR_PU_ST, 32'h0000_ffff},
      '{ADDR_PD_ON, 32'h0000_00ff, ADDR_PD_ST, 32'hffff_ff00},
      '{ADDR_PU_ON, 32'h0000_0fff, ADDR_PU_ST, 32'h0000_f0ff},
      '{ADDR_OWN_OFF, 32'h0000_00ff, ADDR_OWN_ST, 32'hffff_0001},
      '{ADDR_OWN_ON, 32'h0000_000f, ADDR_OWN_ST, 32'hffff_000f},
      '{ADDR_SEL_LO, 32'h0000_00f1, ADDR_SEL_LO, 32'h0000_00f0},
      '{ADDR_DRV_ST, 32'h0000_0000, ADDR_DRV_ST, 32'hf0ff_0000}};
   // Status addresses and their values straight after reset
   logic [AW-1:0] rst_a [10] = '{ADDR_OWN_ST, ADDR_SEL_LO, ADDR_SEL_HI,
      ADDR_DRV_ST, ADDR_LVL_ST, ADDR_DW_ST, ADDR_OD_ST, ADDR_PU_ST,
      ADDR_PD_ST, ADDR_CLK};
   logic [31:0] rst_e [10] = '{OWN_RST, 0, 0, 0, 0, 0, 0, 0, '1, 0};

   iolcm_top #(.OWN_RESET(OWN_RST), .MUXED(MUX)) iolcm_top_inst (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_off(pu_off),
      .pad_pulldown_off(pd_off), .fn_out(fn_out), .fn_oe(fn_oe),
      .periph_in(periph_in));
   iolcm_pads #(.P_OUT(F_OUT), .P_OE(F_OE)) iolcm_pads_inst (
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_off(pu_off),
      .pad_pulldown_off(pd_off), .ext_level(ext_level), .pad_in(pad_in),
      .fn_out(fn_out), .fn_oe(fn_oe));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Counts every compare; a mismatch is reported at once
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One APB transfer; the request stands until pready is seen high
   task automatic apb(input logic we, input logic [AW-1:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= we;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         finish_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Works out the pins from the register state, then compares them
   task automatic pads(input iolcm_vec_type own, sl, sh, drv, lvl, od);
      iolcm_vec_type eo, ee;
      logic v;
      logic [1:0] f;
      for (int i = 0; i < LINES; i++) begin
         f = {sh[i], sl[i]};
         v = own[i] ? lvl[i] : F_OUT[32*f+i];
         ee[i] = (own[i] ? drv[i] : F_OE[32*f+i]) & ~(od[i] & v);
         eo[i] = v & ~od[i];
      end
      // Pads follow the registers one cycle later; leave margin
      repeat (4) @(posedge clk);
      chk(pad_out, eo);
      chk(pad_oe, ee);
   endtask

   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      ext_level = '0;
      failures = 0;
      n_compared = 0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, rst_a[i], 32'h0, rd, err);
         chk(rd, rst_e[i]);
      end
      pads(OWN_RST, '0, '0, '0, '0, '0);
      $display("test reset done");
      // The clock stays off through the table: writes must still land
      foreach (rows[i]) begin
         apb(1'b1, rows[i].wa, rows[i].wd, rd, err);
         apb(1'b0, rows[i].ra, 32'h0, rd, err);
         chk(rd, rows[i].ex);
      end
      chk(pu_off, 32'h0000_f0ff);
      chk(pd_off, 32'hffff_ff00);
      $display("test table done");
      // Function D on lines 6-7 and open drain on both kinds of owner
      apb(1'b1, ADDR_SEL_HI, 32'h0000_00c0, rd, err);
      apb(1'b1, ADDR_OD_ON, 32'h0004_0100, rd, err);
      pads(32'hffff_000f, 32'h0000_00f0, 32'h0000_00c0, 32'hf0ff_0000,
         32'h1234_5611, 32'h0004_0101);
      // Hand lines 8-15 back: the preset drive and level take over
      apb(1'b1, ADDR_OWN_ON, 32'h0000_ff00, rd, err);
      pads(32'hffff_ff0f, 32'h0000_00f0, 32'h0000_00c0, 32'hf0ff_0000,
         32'h1234_5611, 32'h0004_0101);
      $display("test output path done");
      apb(1'b0, 8'hfc, 32'h0, rd, err);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("test unmapped done");
      // Lines 12-15 float and follow the outside level
      ext_level <= 32'h0000_f000;
      repeat (8) @(posedge clk);
      apb(1'b0, ADDR_PIN, 32'h0, rd, err);
      chk(rd, 32'h0);
      chk(periph_in, pad_in);
      apb(1'b1, ADDR_CLK, 32'h0000_0001, rd, err);
      repeat (8) @(posedge clk);
      apb(1'b0, ADDR_PIN, 32'h0, rd, err);
      chk(rd, pad_in);
      old = pad_in;
      apb(1'b1, ADDR_CLK, 32'h0000_0000, rd, err);
      ext_level <= 32'h0000_0000;
      repeat (8) @(posedge clk);
      apb(1'b0, ADDR_PIN, 32'h0, rd, err);
      chk(rd, old);
      chk(periph_in, pad_in);
      $display("test pin level done");
      // Second reset in mid-run restores the OWN_RST ownership value given to the bench
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      apb(1'b0, ADDR_OWN_ST, 32'h0, rd, err);
      chk(rd, OWN_RST);
      $display("test second reset done");
      finish_test();
   end
endmodule
`default_nettype wire

// ### testbench/iolcm_pads.sv
// Pad ring and peripheral function model facing the I/O line block
`timescale 1ns/1ps
`default_nettype none
module iolcm_pads #(
   parameter logic [127:0] P_OUT = '0, // Level each function drives
   parameter logic [127:0] P_OE = '0 // Lines each function drives
) (
   input wire iolcm_pkg::iolcm_vec_type pad_out,
   input wire iolcm_pkg::iolcm_vec_type pad_oe,
   input wire iolcm_pkg::iolcm_vec_type pad_pullup_off,
   input wire iolcm_pkg::iolcm_vec_type pad_pulldown_off,
   input wire iolcm_pkg::iolcm_vec_type ext_level,
   output iolcm_pkg::iolcm_vec_type pad_in,
   output logic [4*iolcm_pkg::LINES-1:0] fn_out,
   output logic [4*iolcm_pkg::LINES-1:0] fn_oe
);
   import iolcm_pkg::*;
   // Fixed patterns, so that every function choice is visible at the pins
   assign fn_out = P_OUT;
   assign fn_oe = P_OE;
   // Driven pin wins, then an active pull, then the outside world
   // Open-drain lines released high rely on the pull or on the outside
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~pad_pullup_off) |
      (~pad_oe & pad_pullup_off & pad_pulldown_off & ext_level);
endmodule
`default_nettype wire
